// ===== shared/cdb_pkg.sv
package cdb_pkg;

  // Register byte offsets
  localparam logic [7:0] AUX1_OFS   = 8'h00;
  localparam logic [7:0] DIV_OFS    = 8'h04;
  localparam logic [7:0] PORT2_MODE_REG_ONE_OFS   = 8'h08;
  localparam logic [7:0] IEN0_OFS   = 8'h0C;
  localparam logic [7:0] POWER_CONTROL_REG_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS   = 8'h14;
  localparam logic [7:0] MASK_OFS   = 8'h18;
  localparam logic [7:0] STATE_OFS  = 8'h1C;

  // Field positions
  localparam int BOI_SEL_BIT   = 5;
  localparam int BO_DIS_BIT    = 6;
  localparam int CLKOUT_EN_BIT = 6;
  localparam int GIE_BIT       = 7;
  localparam int BO_IE_BIT     = 5;
  localparam int BO_FLAG_BIT   = 5;
  localparam int ST_BO_BIT     = 0;
  localparam int ST_WAKE_BIT   = 1;

  // Reset values
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Cycle counts
  localparam logic [10:0] WAKE_XTAL_CLKS = 11'h400;
  localparam logic [10:0] WAKE_RC_CLKS   = 11'h100;
  localparam logic [2:0]  CLKOUT_HALF    = 3'h3;
  localparam logic [2:0]  MC_CLKS        = 3'h6;
  localparam logic [1:0]  CFG_SETTLE     = 2'h3;

  typedef enum logic [2:0] {
    OSC_LF_XTAL,
    OSC_MF_XTAL,
    OSC_HF_XTAL,
    OSC_INT_RC,
    OSC_EXT_CLK
  } cdb_osc_t;

  typedef struct packed {
    cdb_osc_t osc_sel;
    logic     compat_halve_clock_cfg;
    logic     brownout_level_select;
  } cdb_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cdb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cdb_apb_rsp_t;

endpackage

// ===== hw/cdb_divider.sv
`timescale 1ns/10ps
module cdb_divider
  import cdb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [10:0] period,
  output logic             tick
);

  logic [10:0] cnt;
  logic [10:0] cur;

  // New period taken only at a wrap, so no short CPU clock appears
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt  <= 11'h000;
      cur  <= 11'h001;
      tick <= 1'b0;
    end
    else if (cnt >= cur - 11'h001)
    begin
      cnt  <= 11'h000;
      cur  <= period; // [RQ18] [RQ6]
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 11'h001;
      tick <= 1'b0;
    end
  end

  period_edge_a: assert property (@(posedge clk) disable iff (srst) // [RQ18]
    (cur != $past(cur)) |-> (cnt == 11'h000 && tick))
    else $error("divider period changed mid period");

endmodule

// ===== hw/cdb_top.sv
// Overview of operation
// RQ1: Oscillator source comes from nonvolatile strap, never from writes.
// RQ2: External clock mode is static down to stop; second pin freed.
// RQ3: Six CPU clocks per machine cycle; compat bit halves the CPU clock.
// RQ4: Divider zero gives oscillator rate, or half with compat bit.
// RQ5: Divider value N from 1 to 255 divides by two times N plus one.
// RQ6: Divider may be rewritten any time without stopping execution.
// RQ7: Clock out only for RC or external source, enabled, oscillator on.
// RQ8: Clock output runs at one sixth of the CPU clock.
// RQ9: Brownout resets by default; select bit turns it into an interrupt.
// RQ10: Two thresholds; trip stays active while supply is below threshold.
// RQ11: In reset mode the CPU is held in reset while trip stays.
// RQ12: In interrupt mode one request only on the falling supply crossing.
// RQ13: Brownout interrupt served only with global and brownout enables set.
// RQ14: Any brownout sets a sticky flag cleared only by software.
// RQ15: Level strap one picks the low threshold, zero picks the high one.
// RQ16: Brownout disable bit turns the detector off entirely.
// RQ17: Wakeup waits 1024 CPU clocks for crystals, 256 for RC or external.
// RQ18: Divider change applied only at a divided period boundary.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module cdb_top
  import cdb_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  input  cdb_apb_req_t apb_req,
  output cdb_apb_rsp_t apb_rsp,
  input  wire logic [2:0] nv_osc_sel_pin,
  input  wire logic   nv_compat_pin,
  input  wire logic   nv_level_pin,
  input  wire logic   bo_trip_low_pin,
  input  wire logic   bo_trip_high_pin,
  input  wire logic   osc_running,
  input  wire logic   wake_start,
  input  wire logic   irq_ack,
  output logic        cpu_clk_tick,
  output logic        machine_cycle_tick,
  output logic        clock_output_pin_o,
  output logic        clock_output_pin_oe,
  output logic        osc_out_port_free,
  output logic        bo_detector_enable,
  output logic        cpu_reset_hold,
  output logic        brownout_irq_req,
  output logic        cpu_run,
  output logic        irq
);

  logic [4:0]  cfg_s1;
  logic [4:0]  cfg_s2;
  logic [1:0]  cfg_wait;
  cdb_cfg_t    cfg;
  logic [1:0]  trip_s1;
  logic [1:0]  trip_s2;
  logic        aux_irq_select;
  logic        aux_disable;
  logic [7:0]  cpu_clock_divider_value;
  logic        clock_output_enable;
  logic        ien_global;
  logic        ien_bo;
  logic        brownout_occurred_flag;
  logic [1:0]  int_status;
  logic [1:0]  int_mask;
  logic        bo_trip;
  logic        bo_pend;
  logic        bo_pend_src;
  logic [10:0] period;
  logic        div_tick;
  logic [2:0]  mc_cnt;
  logic [2:0]  co_cnt;
  logic [10:0] wake_cnt;
  logic        src_rc_ext;
  logic        wr_en;
  logic        bo_rise;
  logic        wake_done;
  logic [10:0] wake_lim;
  logic [10:0] next_period;
  logic [31:0] next_rdata;
  logic        next_err;

  // Straps and analog trip levels arrive from outside the clock domain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_s1  <= 5'h00;
      cfg_s2  <= 5'h00;
      trip_s1 <= 2'h0;
      trip_s2 <= 2'h0;
    end
    else
    begin
      cfg_s1  <= {nv_osc_sel_pin, nv_compat_pin, nv_level_pin};
      cfg_s2  <= cfg_s1;
      trip_s1 <= {bo_trip_low_pin, bo_trip_high_pin};
      trip_s2 <= trip_s1;
    end
  end

  // Configuration loaded on the first three cycles after reset, then held; software has no path to it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_wait <= 2'h0;
      cfg      <= '{OSC_INT_RC, 1'b0, 1'b1};
    end
    else if (cfg_wait != CFG_SETTLE)
    begin
      cfg_wait <= cfg_wait + 2'h1;
      cfg      <= '{cdb_osc_t'(cfg_s2[4:2]), cfg_s2[1], cfg_s2[0]}; // [RQ1]
    end
  end

  assign src_rc_ext = (cfg.osc_sel == OSC_INT_RC) ||
                      (cfg.osc_sel == OSC_EXT_CLK);
  assign wr_en   = apb_req.psel & apb_req.penable & apb_rsp.pready &
                   apb_req.pwrite;
  assign bo_rise = bo_trip & ~bo_pend_src;

  // APB read mux and decode, answered one cycle after setup
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (apb_req.paddr == AUX1_OFS)
    begin
      next_rdata[BOI_SEL_BIT] = aux_irq_select;
      next_rdata[BO_DIS_BIT]  = aux_disable;
    end
    else if (apb_req.paddr == DIV_OFS)
      next_rdata[7:0] = cpu_clock_divider_value;
    else if (apb_req.paddr == PORT2_MODE_REG_ONE_OFS)
      next_rdata[CLKOUT_EN_BIT] = clock_output_enable;
    else if (apb_req.paddr == IEN0_OFS)
    begin
      next_rdata[GIE_BIT]   = ien_global;
      next_rdata[BO_IE_BIT] = ien_bo;
    end
    else if (apb_req.paddr == POWER_CONTROL_REG_OFS)
      next_rdata[BO_FLAG_BIT] = brownout_occurred_flag;
    else if (apb_req.paddr == STAT_OFS)
      next_rdata[1:0] = int_status;
    else if (apb_req.paddr == MASK_OFS)
      next_rdata[1:0] = int_mask;
    else if (apb_req.paddr == STATE_OFS)
      next_rdata[7:0] = {bo_pend, cpu_run, bo_trip, cfg};
    else
      next_err = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      apb_rsp <= '0;
    else if (apb_req.psel & ~apb_req.penable)
    begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= next_err;
      apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : next_rdata;
    end
    else
      apb_rsp <= '0;
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aux_irq_select          <= 1'b0;
      aux_disable             <= 1'b0;
      cpu_clock_divider_value <= DIV_RST;
      clock_output_enable     <= 1'b0;
      ien_global              <= 1'b0;
      ien_bo                  <= 1'b0;
      int_mask                <= MASK_RST;
    end
    else if (wr_en)
    begin
      if (apb_req.paddr == AUX1_OFS)
      begin
        aux_irq_select <= apb_req.pwdata[BOI_SEL_BIT]; // [RQ9]
        aux_disable    <= apb_req.pwdata[BO_DIS_BIT];
      end
      else if (apb_req.paddr == DIV_OFS)
        cpu_clock_divider_value <= apb_req.pwdata[7:0]; // [RQ6]
      else if (apb_req.paddr == PORT2_MODE_REG_ONE_OFS)
        clock_output_enable <= apb_req.pwdata[CLKOUT_EN_BIT];
      else if (apb_req.paddr == IEN0_OFS)
      begin
        ien_global <= apb_req.pwdata[GIE_BIT];
        ien_bo     <= apb_req.pwdata[BO_IE_BIT];
      end
      else if (apb_req.paddr == MASK_OFS)
        int_mask <= apb_req.pwdata[1:0];
    end
  end

  // Brownout detection; level strap 1 picks the lower threshold
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bo_trip            <= 1'b0;
      bo_pend_src        <= 1'b0;
      bo_detector_enable <= 1'b0;
      cpu_reset_hold     <= 1'b0;
    end
    else
    begin
      bo_detector_enable <= ~aux_disable; // [RQ16]
      bo_trip <= ~aux_disable & (cfg.brownout_level_select ? // [RQ15] [RQ10]
                 trip_s2[1] : trip_s2[0]);
      bo_pend_src    <= bo_trip;
      cpu_reset_hold <= bo_trip & ~aux_irq_select; // [RQ11] [RQ9]
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      brownout_occurred_flag <= 1'b0;
      int_status             <= STAT_RST;
    end
    else
    begin
      if (bo_rise)
        brownout_occurred_flag <= 1'b1; // [RQ14]
      else if (wr_en && apb_req.paddr == POWER_CONTROL_REG_OFS &&
               apb_req.pwdata[BO_FLAG_BIT])
        brownout_occurred_flag <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        if ((i == ST_BO_BIT && bo_rise) || (i == ST_WAKE_BIT && wake_done))
          int_status[i] <= 1'b1;
        else if (wr_en && apb_req.paddr == STAT_OFS && apb_req.pwdata[i])
          int_status[i] <= 1'b0;
      end
    end
  end

  // One request per crossing, held until the CPU acknowledges it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bo_pend          <= 1'b0;
      brownout_irq_req <= 1'b0;
      irq              <= 1'b0;
    end
    else
    begin
      if (bo_rise & aux_irq_select)
        bo_pend <= 1'b1; // [RQ12]
      else if (irq_ack)
        bo_pend <= 1'b0;
      brownout_irq_req <= bo_pend & ien_global & ien_bo; // [RQ13]
      irq <= |(int_status & int_mask);
    end
  end

  // Divide factor: 1 or 2*(N+1), doubled again in compatibility timing
  always_comb
  begin
    if (cpu_clock_divider_value == 8'h00)
      next_period = 11'h001; // [RQ4]
    else
      next_period = {2'h0, cpu_clock_divider_value, 1'b0} + 11'h002; // [RQ5]
    if (cfg.compat_halve_clock_cfg)
      next_period = {next_period[9:0], 1'b0}; // [RQ3]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      period <= 11'h001;
    else
      period <= next_period;
  end

  // Ticks rather than a gated clock keep the design static at any rate
  cdb_divider u_div // [RQ2] [RQ18]
  (
    .clk    (clk),
    .srst   (srst),
    .period (period),
    .tick   (div_tick)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cpu_clk_tick       <= 1'b0;
      machine_cycle_tick <= 1'b0;
      mc_cnt             <= 3'h0;
    end
    else
    begin
      cpu_clk_tick       <= div_tick;
      machine_cycle_tick <= div_tick && mc_cnt == MC_CLKS - 3'h1; // [RQ3]
      if (div_tick)
        mc_cnt <= (mc_cnt == MC_CLKS - 3'h1) ? 3'h0 : mc_cnt + 3'h1;
    end
  end

  // Clock output toggles every third CPU clock: one sixth of its rate
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      co_cnt              <= 3'h0;
      clock_output_pin_o  <= 1'b0;
      clock_output_pin_oe <= 1'b0;
      osc_out_port_free   <= 1'b0;
    end
    else
    begin
      clock_output_pin_oe <= clock_output_enable & src_rc_ext &
                             osc_running; // [RQ7]
      osc_out_port_free <= src_rc_ext & ~clock_output_enable; // [RQ2]
      if (!clock_output_enable || !src_rc_ext)
      begin
        co_cnt             <= 3'h0;
        clock_output_pin_o <= 1'b0;
      end
      else if (div_tick)
      begin
        if (co_cnt == CLKOUT_HALF - 3'h1)
        begin
          co_cnt             <= 3'h0;
          clock_output_pin_o <= ~clock_output_pin_o; // [RQ8]
        end
        else
          co_cnt <= co_cnt + 3'h1;
      end
    end
  end

  // Oscillator settling count after a power-down wakeup
  assign wake_lim  = src_rc_ext ? WAKE_RC_CLKS : WAKE_XTAL_CLKS;
  assign wake_done = ~cpu_run & div_tick & (wake_cnt == wake_lim - 11'h001);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cpu_run  <= 1'b1;
      wake_cnt <= 11'h000;
    end
    else if (wake_start)
    begin
      cpu_run  <= 1'b0;
      wake_cnt <= 11'h000;
    end
    else if (wake_done)
      cpu_run <= 1'b1; // [RQ17]
    else if (!cpu_run && div_tick)
      wake_cnt <= wake_cnt + 11'h001;
  end

  reset_hold_a: assert property (@(posedge clk) disable iff (srst) // [RQ11]
    (bo_trip && !aux_irq_select) |=> cpu_reset_hold)
    else $error("brownout reset not held");

  bo_flag_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    bo_rise |=> brownout_occurred_flag && int_status[ST_BO_BIT])
    else $error("brownout flag not set");

  single_irq_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (!bo_pend ##1 bo_pend) |-> $past(bo_rise && aux_irq_select))
    else $error("brownout request without a crossing");

  irq_gate_a: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    brownout_irq_req |-> $past(ien_global && ien_bo && bo_pend))
    else $error("brownout request raised while disabled");

  bo_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ16]
    aux_disable |=> (!bo_trip && !bo_detector_enable))
    else $error("detector active while disabled");

  clkout_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    (!clock_output_enable || !osc_running) |=> !clock_output_pin_oe)
    else $error("clock output driven while disabled");

  mc_align_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    machine_cycle_tick |-> cpu_clk_tick && $past(mc_cnt) == 3'h5)
    else $error("machine cycle not on sixth CPU clock");

  wake_wait_a: assert property (@(posedge clk) disable iff (srst) // [RQ17]
    $fell(cpu_run) |-> !cpu_run [*8])
    else $error("execution resumed too early after wakeup");

endmodule

// ===== dv/cdb_supply_model.sv
`timescale 1ns/10ps
module cdb_supply_model
(
  input  wire logic [12:0] supply_mv,
  output logic             bo_trip_low_pin,
  output logic             bo_trip_high_pin
);
  // Comparators stay tripped for as long as the supply sits below each level
  assign bo_trip_low_pin  = (supply_mv < 13'h09C4);
  assign bo_trip_high_pin = (supply_mv < 13'h0ED8);
endmodule

// ===== dv/cdb_top_bench.sv
`timescale 1ns/10ps
module cdb_top_bench
  import cdb_pkg::*;
;
  logic         clk;
  logic         srst;
  cdb_apb_req_t req;
  cdb_apb_rsp_t rsp;
  logic [2:0]   osc_sel;
  logic         compat, level, trip_lo, trip_hi, osc_on, wake, ack;
  logic [12:0]  supply_mv;
  logic         cpu_tick, mc_tick, co_o, co_oe, port_free, bo_en;
  logic         rst_hold, bo_req, cpu_run, irq;
  int           error_cnt;
  int           checks_done;

  cdb_supply_model i_supply (
    .supply_mv(supply_mv), .bo_trip_low_pin(trip_lo),
    .bo_trip_high_pin(trip_hi));

  cdb_top i_dut (
    .clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
    .nv_osc_sel_pin(osc_sel), .nv_compat_pin(compat),
    .nv_level_pin(level), .bo_trip_low_pin(trip_lo),
    .bo_trip_high_pin(trip_hi), .osc_running(osc_on),
    .wake_start(wake), .irq_ack(ack), .cpu_clk_tick(cpu_tick),
    .machine_cycle_tick(mc_tick), .clock_output_pin_o(co_o),
    .clock_output_pin_oe(co_oe), .osc_out_port_free(port_free),
    .bo_detector_enable(bo_en), .cpu_reset_hold(rst_hold),
    .brownout_irq_req(bo_req), .cpu_run(cpu_run), .irq(irq));

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is seen high; data is taken at that edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1)
      error_cnt++;
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic sup(input logic [12:0] v);
    @(posedge clk);
    supply_mv <= v;
    wt(8);
  endtask

  // Clock cycles between two events: 0 cpu tick, 1 machine cycle, 2 clkout rise
  task automatic span(input int sel, output logic [31:0] p);
    logic last;
    logic hit;
    int   n;
    last = co_o;
    n = 0;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        hit = (sel == 0) ? cpu_tick : (sel == 1) ? mc_tick : (co_o && !last);
        last = co_o;
        n++;
      end while (hit !== 1'b1 && n < 5000);
    end
    p = n;
  endtask

  task automatic boot(input logic [2:0] o, input logic c, input logic l);
    @(posedge clk);
    srst <= 1'b1;
    osc_sel <= o;
    compat <= c;
    level <= l;
    supply_mv <= 13'h1388;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    wt(8);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    boot(3'h3, 1'b0, 1'b1);
    rd(DIV_OFS, r);
    check(r, {24'h0, DIV_RST});
    rd(STAT_OFS, r);
    check(r, {30'h0, STAT_RST});
    rd(MASK_OFS, r);
    check(r, {30'h0, MASK_RST});
    wr(STATE_OFS, 32'h0);
    rd(STATE_OFS, r);
    check(r, 32'h4D);
    apb(1'b1, 8'h40, 32'hFF, r, e);
    check(e, 1'b1);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    $display("test registers done");
  endtask

  task automatic t_div();
    logic [31:0] p;
    span(0, p);
    check(p, 32'h1);
    span(1, p);
    check(p, 32'h6);
    wr(PORT2_MODE_REG_ONE_OFS, 32'h40);
    wt(2);
    check({co_oe, port_free}, 32'h2);
    span(2, p);
    check(p, 32'h6);
    wr(DIV_OFS, 32'hFF);
    wt(4);
    span(0, p);
    check(p, 32'h200);
    wr(DIV_OFS, 32'h1);
    span(0, p);
    span(0, p);
    check(p, 32'h4);
    span(1, p);
    check(p, 32'h18);
    span(2, p);
    check(p, 32'h18);
    wr(DIV_OFS, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      span(0, p);
      check(p == 32'h4 || p == 32'h8, 1'b1);
    end
    check(p, 32'h8);
    $display("test divider done");
  endtask

  task automatic t_src();
    logic [31:0] p;
    boot(3'h3, 1'b1, 1'b1);
    span(0, p);
    check(p, 32'h2);
    span(1, p);
    check(p, 32'hC);
    boot(3'h0, 1'b0, 1'b1);
    wr(PORT2_MODE_REG_ONE_OFS, 32'h40);
    wt(2);
    check({co_oe, port_free}, 32'h0);
    boot(3'h4, 1'b0, 1'b1);
    check(port_free, 1'b1);
    wr(PORT2_MODE_REG_ONE_OFS, 32'h40);
    wt(2);
    check(co_oe, 1'b1);
    @(posedge clk);
    osc_on <= 1'b0;
    wt(3);
    check(co_oe, 1'b0);
    @(posedge clk);
    osc_on <= 1'b1;
    $display("test sources done");
  endtask

  task automatic t_borst();
    logic [31:0] r;
    for (int l = 0; l < 2; l++)
    begin
      boot(3'h3, 1'b0, l[0]);
      sup(13'h0BB8);
      check(rst_hold, !l[0]);
      sup(13'h1388);
    end
    sup(13'h07D0);
    wt(20);
    check(rst_hold, 1'b1);
    rd(POWER_CONTROL_REG_OFS, r);
    check(r, 32'h20);
    sup(13'h1388);
    check(rst_hold, 1'b0);
    rd(POWER_CONTROL_REG_OFS, r);
    check(r, 32'h20);
    wr(POWER_CONTROL_REG_OFS, 32'h20);
    rd(POWER_CONTROL_REG_OFS, r);
    check(r, 32'h0);
    $display("test brownout reset done");
  endtask

  task automatic t_boirq();
    wr(AUX1_OFS, 32'h20);
    wr(IEN0_OFS, 32'h20);
    sup(13'h07D0);
    check({rst_hold, bo_req}, 32'h0);
    wr(IEN0_OFS, 32'hA0);
    wt(2);
    check(bo_req, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wt(20);
    check(bo_req, 1'b0);
    check(irq, 1'b0);
    wr(MASK_OFS, 32'h1);
    wt(2);
    check(irq, 1'b1);
    wr(STAT_OFS, 32'h1);
    wt(2);
    check(irq, 1'b0);
    sup(13'h1388);
    wr(AUX1_OFS, 32'h40);
    sup(13'h07D0);
    check({bo_en, rst_hold, bo_req}, 32'h0);
    sup(13'h1388);
    $display("test brownout interrupt done");
  endtask

  task automatic t_wake();
    logic [31:0] r;
    int          n;
    for (int s = 0; s < 2; s++)
    begin
      boot(s ? 3'h2 : 3'h3, 1'b0, 1'b1);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(negedge clk);
      n = 0;
      for (int i = 0; i < 3000 && cpu_run !== 1'b1; i++)
      begin
        n += (cpu_tick === 1'b1);
        @(negedge clk);
      end
      r = {21'h0, s ? WAKE_XTAL_CLKS : WAKE_RC_CLKS};
      check(n, r);
      rd(STAT_OFS, r);
      check(r, 32'h2);
    end
    $display("test wakeup done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The whole run needs some 4000 cycles; the 50000-cycle limit leaves ample margin
  initial
  begin
    #5000000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    srst = 1'b1;
    req = '0;
    osc_sel = 3'h3;
    compat = 1'b0;
    level = 1'b1;
    supply_mv = 13'h1388;
    osc_on = 1'b1;
    wake = 1'b0;
    ack = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    t_regs();
    t_div();
    t_src();
    t_borst();
    t_boirq();
    t_wake();
    end_of_test();
  end
endmodule
